// ### logic/cpd_dialog.sv
module cpd_dialog
    import cpd_pkg::*;
#(
    parameter logic [31:0] PC_INIT = PC_RESET
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // interrupt
    output logic irq_out,
    // coprocessor pins
    output logic cir_sel_out,
    output logic cir_wr_out,
    output logic [4:0] cir_addr_out,
    output logic [31:0] cir_wdata_out,
    input wire logic cir_ack_in,
    input wire logic [31:0] cir_rdata_in
);
    cpd_cir_if cir();

    cpd_state_e st_r;
    cpd_kind_e kind_r;
    logic cir_req_r;
    logic cir_wr_r;
    logic [4:0] cir_addr_r;
    logic [31:0] cir_wdata_r;
    logic [15:0] prim_r;
    logic [15:0] cmd_r;
    logic [15:0] sel_r;
    logic [31:0] pc_r;
    logic [31:0] scan_r;
    logic [31:0] opa_r;
    logic ev_done_r;
    logic ev_prot_r;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] stat_nxt;
    logic [STAT_W-1:0] mask_r;
    logic apb_wr;
    logic go;
    logic busy;
    logic [4:0] fn;
    cpd_kind_e go_kind;

    assign cir.req = cir_req_r;
    assign cir.wr = cir_wr_r;
    assign cir.addr = cir_addr_r;
    assign cir.wdata = cir_wdata_r;

    cpd_cir_port u_port (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .eng(cir),
        .cir_sel_out(cir_sel_out),
        .cir_wr_out(cir_wr_out),
        .cir_addr_out(cir_addr_out),
        .cir_wdata_out(cir_wdata_out),
        .cir_ack_in(cir_ack_in),
        .cir_rdata_in(cir_rdata_in)
    );

    ////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic prim_known(input logic [4:0] f);
        return (f == FN_NULL) || (f == FN_EXT) || (f == FN_SCAN) ||
            (f == FN_OPA) || (f == FN_SEL);
    endfunction

    // words already consumed before the first response read
    function automatic logic [31:0] scan_ofs(input cpd_kind_e k);
        if (k == KIND_GEN) begin
            return SCAN_GEN;
        end else if (k == KIND_BR) begin
            return SCAN_BR;
        end else begin
            return SCAN_CND;
        end
    endfunction

    function automatic logic [32:0] rd_word(input logic [7:0] a);
        if (a == A_CTRL) begin
            return {1'b0, cmd_r, 12'h000, kind_r, busy};
        end else if (a == A_PC) begin
            return {1'b0, pc_r};
        end else if (a == A_SCAN) begin
            return {1'b0, scan_r};
        end else if (a == A_STAT) begin
            return {1'b0, 29'h0, busy, stat_r};
        end else if (a == A_MASK) begin
            return {1'b0, 30'h0, mask_r};
        end else if (a == A_SEL) begin
            return {1'b0, 16'h0000, sel_r};
        end else if (a == A_PRIM) begin
            return {1'b0, 16'h0000, prim_r};
        end else if (a == A_OPA) begin
            return {1'b0, opa_r};
        end else begin
            return {1'b1, 32'h0000_0000};
        end
    endfunction

    assign fn = prim_r[FN_HI:FN_LO];
    assign busy = (st_r != S_IDLE);
    assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
    assign go = apb_wr && (paddr_in == A_CTRL) && pwdata_in[CTRL_GO];
    assign go_kind = cpd_kind_e'(pwdata_in[CTRL_KIND_LO +: 3]);

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer on the second access cycle

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else if (ce_in) begin
            pready_out <= psel_in & penable_in & ~pready_out;
            if (psel_in & penable_in & ~pready_out) begin
                {pslverr_out, prdata_out} <= rd_word(paddr_in);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dialogue engine

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_r <= S_IDLE;
            kind_r <= KIND_GEN;
            cir_req_r <= 1'b0;
            cir_wr_r <= 1'b0;
            cir_addr_r <= CIR_RESP;
            cir_wdata_r <= 32'h0000_0000;
            prim_r <= 16'h0000;
            cmd_r <= 16'h0000;
            sel_r <= 16'h0000;
            pc_r <= PC_INIT;
            scan_r <= PC_INIT;
            opa_r <= 32'h0000_0000;
            ev_done_r <= 1'b0;
            ev_prot_r <= 1'b0;
        end else if (ce_in) begin
            ev_done_r <= 1'b0;
            ev_prot_r <= 1'b0;
            if (cir.done) begin
                cir_req_r <= 1'b0;
            end
            // software may not move the counter mid-instruction
            if (apb_wr && paddr_in == A_PC && !busy) begin
                pc_r <= pwdata_in;
            end
            if (apb_wr && paddr_in == A_OPA && !busy) begin
                opa_r <= pwdata_in;
            end
            case (st_r)
                S_IDLE: begin
                    if (go) begin
                        kind_r <= go_kind;
                        cmd_r <= pwdata_in[CTRL_CMD_LO +: 16];
                        scan_r <= pc_r + scan_ofs(go_kind);
                        cir_req_r <= 1'b1;
                        cir_wr_r <= 1'b1;
                        cir_addr_r <= (go_kind == KIND_GEN) ?
                            CIR_CMD : CIR_COND;
                        cir_wdata_r <= {16'h0000,
                            pwdata_in[CTRL_CMD_LO +: 16]};
                        st_r <= S_CMD;
                    end
                end
                S_CMD: begin
                    if (cir.done) begin
                        cir_req_r <= 1'b1;
                        cir_wr_r <= 1'b0;
                        cir_addr_r <= CIR_RESP;
                        st_r <= S_RESP;
                    end
                end
                S_RESP: begin
                    if (cir.done) begin
                        prim_r <= cir.rdata[15:0];
                        if (cir.rdata[PCF_BIT]) begin
                            // counter goes out before any service
                            cir_req_r <= 1'b1;
                            cir_wr_r <= 1'b1;
                            cir_addr_r <= CIR_IADDR;
                            cir_wdata_r <= pc_r;
                            st_r <= S_PASS;
                        end else begin
                            st_r <= S_SERV;
                        end
                    end
                end
                S_PASS: begin
                    if (cir.done) begin
                        st_r <= S_SERV;
                    end
                end
                S_SERV: begin
                    st_r <= S_NEXT;
                    if (!prim_known(fn)) begin
                        ev_prot_r <= 1'b1;
                        st_r <= S_IDLE;
                    end else if (fn == FN_EXT) begin
                        scan_r <= scan_r + WORD_STEP;
                    end else if (fn == FN_SCAN) begin
                        cir_req_r <= 1'b1;
                        cir_wr_r <= 1'b1;
                        cir_addr_r <= CIR_IADDR;
                        cir_wdata_r <= scan_r;
                        st_r <= S_XFER;
                    end else if (fn == FN_OPA) begin
                        cir_req_r <= 1'b1;
                        cir_wr_r <= ~prim_r[DIR_BIT];
                        cir_addr_r <= CIR_OPADDR;
                        cir_wdata_r <= opa_r;
                        st_r <= S_XFER;
                    end else if (fn == FN_SEL) begin
                        cir_req_r <= 1'b1;
                        cir_wr_r <= 1'b0;
                        cir_addr_r <= CIR_REGSEL;
                        st_r <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (cir.done) begin
                        if (!cir_wr_r && cir_addr_r == CIR_OPADDR) begin
                            opa_r <= cir.rdata;
                        end
                        if (cir_addr_r == CIR_REGSEL) begin
                            sel_r <= cir.rdata[15:0];
                        end
                        st_r <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    if (prim_r[CA_BIT]) begin
                        cir_req_r <= 1'b1;
                        cir_wr_r <= 1'b0;
                        cir_addr_r <= CIR_RESP;
                        st_r <= S_RESP;
                    end else begin
                        // trusts the coprocessor to leave scan in place
                        pc_r <= scan_r;
                        ev_done_r <= 1'b1;
                        st_r <= S_IDLE;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status, mask, interrupt

    // an event in the clearing cycle survives the clear
    always_comb begin
        stat_nxt = stat_r;
        if (apb_wr && paddr_in == A_STAT) begin
            stat_nxt = stat_nxt & ~pwdata_in[STAT_W-1:0];
        end
        stat_nxt[ST_DONE] = stat_nxt[ST_DONE] | ev_done_r;
        stat_nxt[ST_PROT] = stat_nxt[ST_PROT] | ev_prot_r;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            stat_r <= STAT_RESET;
            mask_r <= STAT_RESET;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            stat_r <= stat_nxt;
            if (apb_wr && paddr_in == A_MASK) begin
                mask_r <= pwdata_in[STAT_W-1:0];
            end
            irq_out <= |(stat_nxt & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in || !ce_in);

    sequence s_pc_prim;
        st_r == S_RESP && cir.done && cir.rdata[PCF_BIT];
    endsequence

    sequence s_pc_out;
        st_r == S_PASS && cir_req_r && cir_wr_r &&
            cir_addr_r == CIR_IADDR && cir_wdata_r == pc_r;
    endsequence

    sel_read_a: assert property (
        (st_r == S_SERV && fn == FN_SEL && prim_known(fn)) |=>
            cir_req_r && !cir_wr_r && cir_addr_r == CIR_REGSEL)
        else $error("register selector not read");

    scan_xfer_a: assert property (
        (st_r == S_SERV && fn == FN_SCAN) |=> cir_wr_r &&
            cir_addr_r == CIR_IADDR && cir_wdata_r == $past(scan_r))
        else $error("scan pointer not sent to address port");

    opaddr_dir_a: assert property (
        (st_r == S_SERV && fn == FN_OPA) |=> cir_addr_r == CIR_OPADDR &&
            cir_wr_r == !$past(prim_r[DIR_BIT]))
        else $error("operand address direction wrong");

    pass_pc_a: assert property (
        s_pc_prim |=> s_pc_out)
        else $error("counter not passed first");

    pc_hold_a: assert property (
        (busy && st_r != S_NEXT) |=> $stable(pc_r))
        else $error("counter moved mid-instruction");

    scan_start_a: assert property (
        (st_r == S_IDLE && go && go_kind == KIND_BR) |=>
            scan_r == $past(pc_r) + SCAN_BR)
        else $error("scan pointer start wrong");

    ext_step_a: assert property (
        (st_r == S_SERV && fn == FN_EXT) |=>
            scan_r == $past(scan_r) + WORD_STEP)
        else $error("scan pointer did not step");

    finish_copy_a: assert property (
        (st_r == S_NEXT && !prim_r[CA_BIT]) |=>
            pc_r == $past(scan_r) && st_r == S_IDLE ##1 stat_r[ST_DONE])
        else $error("scan pointer not copied at finish");

    come_again_a: assert property (
        (st_r == S_NEXT && prim_r[CA_BIT]) |=>
            st_r == S_RESP && cir_req_r && cir_addr_r == CIR_RESP)
        else $error("response not reread");

    unknown_prim_a: assert property (
        (st_r == S_SERV && !prim_known(fn)) |=>
            ev_prot_r && st_r == S_IDLE ##1 stat_r[ST_PROT])
        else $error("unknown primitive not flagged");
endmodule // cpd_dialog

// ### logic/cpd_pkg.sv
package cpd_pkg;
    // software register map (byte addresses)
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_PC = 8'h04;
    localparam logic [7:0] A_SCAN = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    localparam logic [7:0] A_MASK = 8'h10;
    localparam logic [7:0] A_SEL = 8'h14;
    localparam logic [7:0] A_PRIM = 8'h18;
    localparam logic [7:0] A_OPA = 8'h1c;
    // coprocessor interface register offsets
    localparam logic [4:0] CIR_RESP = 5'h00;
    localparam logic [4:0] CIR_CMD = 5'h0a;
    localparam logic [4:0] CIR_COND = 5'h0e;
    localparam logic [4:0] CIR_REGSEL = 5'h14;
    localparam logic [4:0] CIR_IADDR = 5'h18;
    localparam logic [4:0] CIR_OPADDR = 5'h1c;
    // response primitive fields
    localparam int CA_BIT = 15;
    localparam int PCF_BIT = 14;
    localparam int DIR_BIT = 13;
    localparam int FN_HI = 12;
    localparam int FN_LO = 8;
    // recognised function codes
    localparam logic [4:0] FN_NULL = 5'h02;
    localparam logic [4:0] FN_EXT = 5'h0e;
    localparam logic [4:0] FN_SCAN = 5'h01;
    localparam logic [4:0] FN_OPA = 5'h0a;
    localparam logic [4:0] FN_SEL = 5'h0c;
    // control and status fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_KIND_LO = 1;
    localparam int CTRL_CMD_LO = 16;
    localparam int STAT_W = 2;
    localparam int ST_DONE = 0;
    localparam int ST_PROT = 1;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    // scan pointer offsets from the operation word
    localparam logic [31:0] SCAN_GEN = 32'h0000_0004;
    localparam logic [31:0] SCAN_BR = 32'h0000_0002;
    localparam logic [31:0] SCAN_CND = 32'h0000_0004;
    localparam logic [31:0] WORD_STEP = 32'h0000_0002;

    typedef enum logic [2:0] {
        KIND_GEN = 3'b000,
        KIND_BR = 3'b001,
        KIND_SET = 3'b010,
        KIND_TRAP = 3'b011,
        KIND_DBR = 3'b100
    } cpd_kind_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CMD = 3'b001,
        S_RESP = 3'b010,
        S_PASS = 3'b011,
        S_SERV = 3'b100,
        S_XFER = 3'b101,
        S_NEXT = 3'b110
    } cpd_state_e;
endpackage

// ### logic/cpd_cir_if.sv
interface cpd_cir_if;
    logic req;
    logic wr;
    logic [4:0] addr;
    logic [31:0] wdata;
    logic done;
    logic [31:0] rdata;
    modport eng (output req, wr, addr, wdata, input done, rdata);
    modport port (input req, wr, addr, wdata, output done, rdata);
endinterface

// ### logic/cpd_cir_port.sv
module cpd_cir_port
    import cpd_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // engine side
    cpd_cir_if.port eng,
    // coprocessor pins
    output logic cir_sel_out,
    output logic cir_wr_out,
    output logic [4:0] cir_addr_out,
    output logic [31:0] cir_wdata_out,
    input wire logic cir_ack_in,
    input wire logic [31:0] cir_rdata_in
);
    logic done_r;
    logic [31:0] rdata_r;

    assign eng.done = done_r;
    assign eng.rdata = rdata_r;

    // done is a one-cycle pulse; engine drops req on it or sets up its next access
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cir_sel_out <= 1'b0;
            cir_wr_out <= 1'b0;
            cir_addr_out <= 5'h00;
            cir_wdata_out <= 32'h0000_0000;
            done_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            done_r <= 1'b0;
            if (!cir_sel_out && eng.req && !done_r) begin
                cir_sel_out <= 1'b1;
                cir_wr_out <= eng.wr;
                cir_addr_out <= eng.addr;
                cir_wdata_out <= eng.wdata;
            end else if (cir_sel_out && cir_ack_in) begin
                cir_sel_out <= 1'b0;
                done_r <= 1'b1;
                rdata_r <= cir_rdata_in;
            end
        end
    end
endmodule // cpd_cir_port

// ### test/cpd_coproc_model.sv
module cpd_coproc_model
    import cpd_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // coprocessor pins
    input wire logic cir_sel_in,
    input wire logic cir_wr_in,
    input wire logic [4:0] cir_addr_in,
    input wire logic [31:0] cir_wdata_in,
    output logic cir_ack_out,
    output logic [31:0] cir_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // scripted primitives, loaded by the bench before each instruction
    logic [15:0] prim_q[$];
    // access log: {write, offset, data}
    logic [37:0] log_q[$];
    logic [15:0] sel_val = 16'h0000;
    logic [31:0] opa_val = 32'h0000_0000;
    int ack_delay = 0;
    int wait_r;
    logic [31:0] rd;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            cir_ack_out <= 1'b0;
            cir_rdata_out <= 32'h5555_aaaa;
            wait_r <= 0;
        end else if (cir_sel_in && !cir_ack_out) begin
            if (wait_r < ack_delay) begin
                wait_r <= wait_r + 1;
                cir_rdata_out <= ~cir_rdata_out;
            end else begin
                wait_r <= 0;
                cir_ack_out <= 1'b1;
                // empty script ends the dialogue with a plain null
                rd = 32'h0000_0200;
                if (cir_addr_in == CIR_RESP && prim_q.size() > 0) begin
                    rd = {16'h0000, prim_q.pop_front()};
                end
                if (cir_addr_in == CIR_REGSEL) begin
                    rd = {16'h0000, sel_val};
                end
                if (cir_addr_in == CIR_OPADDR) begin
                    rd = opa_val;
                end
                if (cir_wr_in) begin
                    log_q.push_back({1'b1, cir_addr_in, cir_wdata_in});
                end else begin
                    log_q.push_back({1'b0, cir_addr_in, rd});
                    cir_rdata_out <= rd;
                end
            end
        end else begin
            // released bus never keeps the last value
            cir_ack_out <= 1'b0;
            cir_rdata_out <= ~cir_rdata_out;
        end
    end
endmodule // cpd_coproc_model

// ### test/cpd_dialog_tb.sv
module cpd_dialog_tb
    import cpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, c_wdata, c_rdata;
    logic pready, pslverr, irq, c_sel, c_wr, c_ack;
    logic [4:0] c_addr;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    cpd_dialog DUT (.clk_in(clk), .reset_n_in(reset_n), .ce_in(1'b1),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
        .cir_sel_out(c_sel), .cir_wr_out(c_wr), .cir_addr_out(c_addr),
        .cir_wdata_out(c_wdata), .cir_ack_in(c_ack),
        .cir_rdata_in(c_rdata));

    cpd_coproc_model CP (.clk_in(clk), .reset_n_in(reset_n),
        .cir_sel_in(c_sel), .cir_wr_in(c_wr), .cir_addr_in(c_addr),
        .cir_wdata_in(c_wdata), .cir_ack_out(c_ack),
        .cir_rdata_out(c_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [39:0] exp,
                       input logic [39:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("apb wait cycles", 2, n);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task automatic run_op(input logic [2:0] k, input logic [15:0] cmd,
                          input logic [31:0] pc, output logic [31:0] st);
        wr(A_STAT, 32'h3);
        CP.log_q.delete();
        wr(A_PC, pc);
        wr(A_CTRL, {cmd, 12'h000, k, 1'b1});
        do begin
            rd(A_STAT, st);
        end while (st[1:0] === 2'b00);
    endtask

    task automatic chk_log(input int i, input logic w, input logic [4:0] a,
                           input logic [31:0] d, input logic [31:0] m);
        logic [37:0] e;
        e = (i < CP.log_q.size()) ? CP.log_q[i] : 'x;
        chk("access kind", w, e[37]);
        chk("access offset", a, e[36:32]);
        chk("access data", d & m, e[31:0] & m);
    endtask

    task automatic irq_is(input logic v);
        repeat (3) @(posedge clk);
        chk("irq", v, irq);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, q, e);
            chk("reset value", 0, q);
            chk("reset err", 0, e);
        end
        wr(A_SCAN, 32'hffff_fffe);
        rd(A_SCAN, q);
        chk("scan read only", 0, q);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, q);
    endtask

    // every instruction kind, slower coprocessor each time
    task automatic t_kinds;
        logic [31:0] st, q, pc, ex;
        for (int k = 0; k < 5; k++) begin
            CP.ack_delay = k;
            CP.prim_q = {16'h0100};
            pc = 32'h0000_1000 + 32'(k * 16);
            ex = pc + ((k == 1) ? 32'h2 : 32'h4);
            run_op(3'(k), 16'h0c00 + 16'(k), pc, st);
            chk_log(0, 1, (k == 0) ? CIR_CMD : CIR_COND,
                    32'h0c00 + 32'(k), 32'hffff);
            chk_log(1, 0, CIR_RESP, 0, 0);
            chk_log(2, 1, CIR_IADDR, ex, 32'hffff_ffff);
            rd(A_PC, q);
            chk("pc after", ex, q);
            chk("status", 1, st[1:0]);
        end
        CP.ack_delay = 0;
    endtask

    // pass counter first, extension skip, come again twice
    task automatic t_chain;
        logic [31:0] st, q;
        CP.prim_q = {16'hce00, 16'h8100};
        run_op(3'd0, 16'h1234, 32'h0000_0100, st);
        chk("log size", 6, CP.log_q.size());
        chk_log(2, 1, CIR_IADDR, 32'h100, 32'hffff_ffff);
        chk_log(3, 0, CIR_RESP, 0, 0);
        chk_log(4, 1, CIR_IADDR, 32'h106, 32'hffff_ffff);
        rd(A_PC, q);
        chk("pc after", 32'h106, q);
        rd(A_PRIM, q);
        chk("last primitive", 32'h0200, q);
        irq_is(1'b0);
        wr(A_MASK, 32'h1);
        irq_is(1'b1);
        wr(A_STAT, 32'h1);
        irq_is(1'b0);
        wr(A_MASK, 32'h0);
    endtask

    // operand address both ways, register selector
    task automatic t_operand;
        logic [31:0] st, q;
        wr(A_OPA, 32'hdead_beef);
        CP.sel_val = 16'h0003;
        CP.opa_val = 32'h1234_5678;
        CP.prim_q = {16'h8a00, 16'h8c05, 16'h2a00};
        run_op(3'd0, 16'h0042, 32'h0000_0200, st);
        chk("log size", 7, CP.log_q.size());
        chk_log(2, 1, CIR_OPADDR, 32'hdead_beef, 32'hffff_ffff);
        chk_log(4, 0, CIR_REGSEL, 0, 0);
        chk_log(6, 0, CIR_OPADDR, 0, 0);
        rd(A_SEL, q);
        chk("selector", 32'h3, q);
        rd(A_OPA, q);
        chk("operand address", 32'h1234_5678, q);
        rd(A_PRIM, q);
        chk("last primitive", 32'h2a00, q);
    endtask

    // unknown function with pass counter set
    task automatic t_unknown;
        logic [31:0] st, q;
        CP.prim_q = {16'h5f00};
        wr(A_MASK, 32'h2);
        run_op(3'd0, 16'h0001, 32'h0000_0300, st);
        chk("status", 2, st[1:0]);
        chk("log size", 3, CP.log_q.size());
        chk_log(2, 1, CIR_IADDR, 32'h300, 32'hffff_ffff);
        rd(A_PC, q);
        chk("pc kept", 32'h300, q);
        irq_is(1'b1);
        wr(A_STAT, 32'h2);
        irq_is(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // the engine waits forever for ack, so a hang is cut here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_kinds();
        t_chain();
        t_operand();
        t_unknown();
        final_report();
    end
endmodule // cpd_dialog_tb
